// ### core/umbm_mover.sv
// unwrapped memory block mover: command decode, sequencer, status
`timescale 1ns/1ps
`default_nettype none
module umbm_mover
  import umbm_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // cpu i/o bus commands
  input  wire logic       dev_selected,
  input  wire logic       stop_clear_command,
  input  wire logic       move_parameter_command,
  input  wire logic       move_command,
  input  wire logic       status_read_command,
  input  wire logic [7:0] cmd_data,
  output logic      [7:0] status_byte,
  // factory options
  input  wire logic       opt_space_fill,
  input  wire logic       opt_cmd80,
  output logic      [7:0] fill_byte,
  // source memory channel
  output logic            src_strobe,
  input  wire logic [7:0] src_data,
  input  wire logic       src_term,
  // destination memory channel
  output logic            dst_strobe,
  output logic      [7:0] dst_data,
  input  wire logic       dst_term,
  // interrupt request, level 3
  output logic            irq
);

  // ******************************************************
  // declarations
  // ******************************************************
  umbm_state_t      state_r;       // sequencer state
  umbm_state_t      state_nxt;
  logic [7:0]       move_param_r;  // move parameter byte
  logic             idle_r;        // not busy flag
  logic             src_flag_r;    // source termination status
  logic             dst_flag_r;    // destination termination status
  logic             src_done_r;    // source reads finished
  logic             prefer_dst_r;  // alternation between channels
  logic [CNT_W-1:0] grp_left_r;    // bytes left in current group
  logic [TMR_W-1:0] tmr_r;         // access timer
  logic [7:0]       dst_data_r;    // byte being stored
  logic [7:0]       status_r;      // captured status byte
  logic [7:0]       fill_r;        // fill character for wrap logic
  logic [7:0]       head_data;     // oldest buffered byte
  logic [CNT_W-1:0] buf_count;     // buffered byte count
  logic             stop;          // accepted stop-clear
  logic             start;         // accepted move
  logic             unwrap_req;    // move command asks for unwrapped mode
  logic             acc_done;      // last cycle of an access
  logic             src_ok;        // a source read is allowed
  logic             do_dst;        // a destination store is due
  logic             finish;        // drain after source end is over
  logic             grp_load;      // start a new destination group
  logic             buf_push;
  logic             buf_pop;

  // ******************************************************
  // command decode
  // ******************************************************
  // all commands are gated by device selection
  assign stop = stop_clear_command & dev_selected;

  // unwrapped when the parameter says so, or by the 80 byte under option two
  assign unwrap_req = move_param_r[PARAM_NOWRAP_BIT]
                    | (opt_cmd80 & (cmd_data == CMD_UNWRAP_BYTE));

  // a move while busy is ignored; stop-clear takes priority
  assign start = move_command & dev_selected & unwrap_req & idle_r & !stop;

  // move parameter byte; stop-clear leaves it alone
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      move_param_r <= BYTE_ZERO;
    end else if (move_parameter_command && dev_selected) begin
      move_param_r <= cmd_data;
    end
  end

  // ******************************************************
  // access timing
  // ******************************************************
  // one access at a time, so command time is access count times 15 us
  assign acc_done = (state_r == UMBM_SRC || state_r == UMBM_DST)
                  && (tmr_r == TMR_LAST);

  // timer runs only inside an access and restarts for each one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= TMR_ZERO;
    end else if (stop || acc_done || state_r == UMBM_IDLE || state_r == UMBM_PICK) begin
      tmr_r <= TMR_ZERO;
    end else begin
      tmr_r <= tmr_r + TMR_ONE;
    end
  end

  // ******************************************************
  // scheduling between the two channels
  // ******************************************************
  // reads stop at source end or when all 320 bytes are held
  assign src_ok = !src_done_r && (buf_count != BUF_FULL);

  // stores alternate with reads inside a group so both run together;
  // a group opening in this pick may store at once, so pick never stalls
  assign do_dst = ((grp_left_r != CNT_ZERO) || grp_load) && (prefer_dst_r || !src_ok);

  // a group opens at 64 bytes, or with the remainder once source ended
  assign grp_load = (state_r == UMBM_PICK) && (grp_left_r == CNT_ZERO)
                  && ((buf_count >= GROUP_BYTES)
                      || (src_done_r && buf_count != CNT_ZERO));

  // cycle is over once the source has ended and nothing is left
  assign finish = src_done_r && (buf_count == CNT_ZERO)
                && (grp_left_r == CNT_ZERO);

  // ******************************************************
  // sequencer
  // ******************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      UMBM_IDLE: begin
        if (start) begin
          state_nxt = UMBM_PICK;
        end
      end
      UMBM_PICK: begin
        if (do_dst) begin
          state_nxt = UMBM_DST;
        end else if (src_ok) begin
          state_nxt = UMBM_SRC;
        end else if (finish) begin
          state_nxt = UMBM_IDLE;
        end
      end
      UMBM_SRC: begin
        if (acc_done) begin
          state_nxt = UMBM_PICK;
        end
      end
      UMBM_DST: begin
        if (acc_done) begin
          // destination end halts every transfer
          state_nxt = dst_term ? UMBM_IDLE : UMBM_PICK;
        end
      end
    endcase
  end

  // state register; stop-clear aborts any access in flight
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= UMBM_IDLE;
    end else if (stop) begin
      state_r <= UMBM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // alternation flag: after a read prefer a store and back again
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prefer_dst_r <= 1'b0;
    end else if (stop) begin
      prefer_dst_r <= 1'b0;
    end else if (acc_done) begin
      prefer_dst_r <= (state_r == UMBM_SRC);
    end
  end

  // group counter; a halted group keeps its remainder for the resume
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      grp_left_r <= CNT_ZERO;
    end else if (stop) begin
      grp_left_r <= CNT_ZERO;
    end else if (grp_load) begin
      grp_left_r <= (buf_count >= GROUP_BYTES) ? GROUP_BYTES : buf_count;
    end else if (buf_pop) begin
      grp_left_r <= grp_left_r - CNT_ONE;
    end
  end

  // ******************************************************
  // channel strobes and buffer traffic
  // ******************************************************
  // a strobe marks the end of an access; source address steps on each,
  // including the read that reports termination
  assign src_strobe = acc_done && (state_r == UMBM_SRC);
  assign dst_strobe = acc_done && (state_r == UMBM_DST);

  // every byte kept as read, nulls included; terminating read stores nothing
  assign buf_push = src_strobe && !src_term;
  // a refused store keeps its byte at the head of the buffer
  assign buf_pop  = dst_strobe && !dst_term;

  // source end latch; only stop-clear rearms source reads
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_done_r <= 1'b0;
    end else if (src_strobe && src_term) begin
      src_done_r <= 1'b1;
    end else if (stop) begin
      src_done_r <= 1'b0;
    end
  end

  // outgoing byte is the head, taken unchanged, no margin or fill logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dst_data_r <= BYTE_ZERO;
    end else if (state_r == UMBM_PICK && do_dst) begin
      dst_data_r <= head_data;
    end
  end

  assign dst_data = dst_data_r;

  // chained auxiliary and secondary store
  umbm_byte_buffer u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .push      (buf_push),
    .push_data (src_data),
    .pop       (buf_pop),
    .head_data (head_data),
    .flush     (stop),
    .count     (buf_count)
  );

  // ******************************************************
  // flags and status
  // ******************************************************
  // idle flag: set on completion, halt or stop, cleared by an accepted move
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= 1'b1;
    end else if (stop) begin
      idle_r <= 1'b1;
    end else if (state_r == UMBM_PICK && state_nxt == UMBM_IDLE) begin
      idle_r <= 1'b1;
    end else if (dst_strobe && dst_term) begin
      idle_r <= 1'b1;
    end else if (start) begin
      idle_r <= 1'b0;
    end
  end

  // source termination status; set wins over the stop-clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_flag_r <= 1'b0;
    end else if (state_r == UMBM_PICK && state_nxt == UMBM_IDLE) begin
      src_flag_r <= 1'b1;
    end else if (stop) begin
      src_flag_r <= 1'b0;
    end
  end

  // destination termination status; a resume clears it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dst_flag_r <= 1'b0;
    end else if (dst_strobe && dst_term) begin
      dst_flag_r <= 1'b1;
    end else if (stop || start) begin
      dst_flag_r <= 1'b0;
    end
  end

  // status byte captured on a read; printer and reserved bits read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= BYTE_ZERO;
    end else if (status_read_command && dev_selected) begin
      status_r                <= BYTE_ZERO;
      status_r[STAT_IDLE_BIT] <= idle_r;
      status_r[STAT_SRC_BIT]  <= src_flag_r;
      status_r[STAT_DST_BIT]  <= dst_flag_r;
    end
  end

  assign status_byte = status_r;

  // interrupt is the idle flag itself, so it is also high out of reset
  assign irq = idle_r;

  // ******************************************************
  // option one fill character
  // ******************************************************
  // only the wrapped mover uses it; the unwrapped path never emits it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_r <= FILL_NULL;
    end else begin
      fill_r <= opt_space_fill ? FILL_SPACE : FILL_NULL;
    end
  end

  assign fill_byte = fill_r;

endmodule
`default_nettype wire

// ### include/umbm_pkg.sv
// constants and types shared by the unwrapped memory block mover
package umbm_pkg;

  // ******************************************************
  // buffer geometry
  // ******************************************************
  localparam int unsigned BUF_DEPTH = 320;           // auxiliary plus secondary bytes
  localparam int unsigned CNT_W     = 9;             // holds 0 .. BUF_DEPTH
  localparam logic [CNT_W-1:0] BUF_FULL    = 9'h140;  // BUF_DEPTH as a count
  localparam logic [CNT_W-1:0] GROUP_BYTES = 9'h040;  // destination group size
  localparam logic [CNT_W-1:0] CNT_ZERO    = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 9'h001;

  // ******************************************************
  // access timing
  // ******************************************************
  localparam int unsigned CLK_MHZ    = 100;          // core_clk rate
  localparam int unsigned ACCESS_US  = 15;           // one byte access
  localparam int unsigned ACCESS_CYC = ACCESS_US * CLK_MHZ;
  localparam int unsigned TMR_W      = 11;
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(ACCESS_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO = 11'h000;
  localparam logic [TMR_W-1:0] TMR_ONE  = 11'h001;

  // ******************************************************
  // command and status encodings
  // ******************************************************
  localparam int unsigned PARAM_NOWRAP_BIT = 7;      // move parameter: no word wrap
  localparam logic [7:0]  CMD_UNWRAP_BYTE  = 8'h80;  // move byte under option two
  localparam int unsigned STAT_IDLE_BIT    = 7;
  localparam int unsigned STAT_SRC_BIT     = 5;
  localparam int unsigned STAT_DST_BIT     = 4;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [7:0]  FILL_NULL        = 8'h00;
  localparam logic [7:0]  FILL_SPACE       = 8'h20;

  // ******************************************************
  // sequencer states, gray coded along idle-pick-src-dst
  // ******************************************************
  typedef enum logic [1:0] {
    UMBM_IDLE = 2'h0,
    UMBM_PICK = 2'h1,
    UMBM_SRC  = 2'h3,
    UMBM_DST  = 2'h2
  } umbm_state_t;

endpackage

// ### core/umbm_byte_buffer.sv
// circular byte store that chains the auxiliary and secondary buffers
`timescale 1ns/1ps
`default_nettype none
module umbm_byte_buffer
  import umbm_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             push,
  input  wire logic [7:0]       push_data,
  // drain side
  input  wire logic             pop,
  output logic      [7:0]       head_data,
  // control and level
  input  wire logic             flush,
  output logic      [CNT_W-1:0] count
);

  // ******************************************************
  // storage and pointers
  // ******************************************************
  logic [7:0]       mem [BUF_DEPTH];  // byte store
  logic [CNT_W-1:0] wr_ptr_r;         // next slot to fill
  logic [CNT_W-1:0] rd_ptr_r;         // oldest byte
  logic [CNT_W-1:0] count_r;          // bytes held

  // pointer step with wrap at the end of the store
  function automatic logic [CNT_W-1:0] ptr_step(input logic [CNT_W-1:0] p);
    ptr_step = (p == BUF_FULL - CNT_ONE) ? CNT_ZERO : p + CNT_ONE;
  endfunction

  // byte store write; no reset so it maps to plain ram
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  // write pointer; flush drops everything held
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= CNT_ZERO;
    end else if (flush) begin
      wr_ptr_r <= CNT_ZERO;
    end else if (push) begin
      wr_ptr_r <= ptr_step(wr_ptr_r);
    end
  end

  // read pointer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_r <= CNT_ZERO;
    end else if (flush) begin
      rd_ptr_r <= CNT_ZERO;
    end else if (pop) begin
      rd_ptr_r <= ptr_step(rd_ptr_r);
    end
  end

  // fill level; caller never pushes when full nor pops when empty
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= CNT_ZERO;
    end else if (flush) begin
      count_r <= CNT_ZERO;
    end else if (push && !pop) begin
      count_r <= count_r + CNT_ONE;
    end else if (pop && !push) begin
      count_r <= count_r - CNT_ONE;
    end
  end

  assign head_data = mem[rd_ptr_r];
  assign count     = count_r;

endmodule
`default_nettype wire

// ### dv/umbm_mover_assertions.sv
// port-level assertion checker for the block mover, bound to the top
`timescale 1ns/1ps
`default_nettype none
module umbm_mover_assertions (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // commands
  input wire logic       dev_selected,
  input wire logic       stop_clear_command,
  input wire logic       move_parameter_command,
  input wire logic       move_command,
  input wire logic       status_read_command,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] status_byte,
  input wire logic       opt_cmd80,
  // memory channels and interrupt
  input wire logic       src_strobe,
  input wire logic       src_term,
  input wire logic       dst_strobe,
  input wire logic [7:0] dst_data,
  input wire logic       dst_term,
  input wire logic       irq
);
  // ******************************************************
  // helper logic
  // ******************************************************
  logic [10:0] acc_cnt_r;  // busy cycles since the last strobe
  logic        src_done_r; // terminating source read seen
  logic        nowrap_r;   // no-wrap bit as last loaded
  wire logic   strobe = src_strobe | dst_strobe;
  wire logic   stop   = stop_clear_command & dev_selected;
  wire logic   go_ok  = nowrap_r | (opt_cmd80 & (cmd_data == 8'h80));
  // cleared while idle so a fresh access always counts from zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) acc_cnt_r <= 11'h000;
    else if (irq || strobe) acc_cnt_r <= 11'h000;
    else acc_cnt_r <= acc_cnt_r + 11'h001;
  end
  // set wins over clear, as in the design's own latch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) src_done_r <= 1'b0;
    else if (src_strobe && src_term) src_done_r <= 1'b1;
    else if (stop) src_done_r <= 1'b0;
  end
  // shadow of the parameter bit that selects unwrapped moves
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) nowrap_r <= 1'b0;
    else if (move_parameter_command && dev_selected) nowrap_r <= cmd_data[7];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ******************************************************
  // assertions
  // ******************************************************
  AST_ACCESS_TIME: assert property (strobe |-> acc_cnt_r == 11'h5dc)
    else $error("byte access not 1500 cycles");
  AST_SERIAL: assert property (!(src_strobe && dst_strobe))
    else $error("two accesses at once");
  AST_IDLE_QUIET: assert property (irq |-> !strobe)
    else $error("access while idle");
  AST_DST_HALT: assert property (dst_strobe && dst_term |=> irq)
    else $error("no halt on destination end");
  AST_STOP_IDLE: assert property (stop |=> irq)
    else $error("stop did not idle");
  AST_MOVE_GO: assert property (move_command && dev_selected && !stop_clear_command
    && irq && go_ok |=> !irq) else $error("move not started");
  AST_MOVE_WRAP: assert property (move_command && irq && !go_ok |=> irq)
    else $error("wrapped move started");
  AST_UNSELECTED: assert property (irq && !dev_selected |=> irq)
    else $error("unselected command taken");
  AST_STATUS_IDLE: assert property (status_read_command && dev_selected
    |=> status_byte[7] == $past(irq)) else $error("status idle differs from irq");
  AST_STATUS_RSVD: assert property (status_byte[6] == 1'b0 && status_byte[3:0] == 4'h0)
    else $error("reserved status bits set");
  AST_SRC_STOPPED: assert property (src_done_r |-> !src_strobe)
    else $error("source read after termination");
  AST_DST_HOLD: assert property (dst_strobe |-> dst_data == $past(dst_data, 8))
    else $error("store data moved during access");
endmodule
bind umbm_mover umbm_mover_assertions i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .dev_selected(dev_selected),
  .stop_clear_command(stop_clear_command), .move_parameter_command(move_parameter_command),
  .move_command(move_command), .status_read_command(status_read_command),
  .cmd_data(cmd_data), .status_byte(status_byte), .opt_cmd80(opt_cmd80),
  .src_strobe(src_strobe), .src_term(src_term), .dst_strobe(dst_strobe),
  .dst_data(dst_data), .dst_term(dst_term), .irq(irq)
);
`default_nettype wire

// ### dv/umbm_mem_model.sv
// source and destination memory channel model facing the mover
`timescale 1ns/1ps
`default_nettype none
module umbm_mem_model (
  // clock, reset, bench control
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       rewind,
  input  wire logic [3:0] src_len,
  input  wire logic [3:0] dst_len,
  // source channel
  input  wire logic       src_strobe,
  output logic      [7:0] src_data,
  output logic            src_term,
  // destination channel
  input  wire logic       dst_strobe,
  input  wire logic [7:0] dst_data,
  output logic            dst_term
);
  logic [3:0] src_addr;     // source current address
  logic [3:0] dst_addr;     // destination current address
  logic [7:0] n_rd;         // source reads seen
  logic [7:0] dst_mem [16]; // stored bytes
  // byte i is {i,0}: holds a null, a space and 8'h80
  wire logic [7:0] cur = {src_addr, 4'h0};
  // outside the strobe the lines show inverted junk, never the real value
  assign src_data = src_strobe ? cur : ~cur;
  assign src_term = src_strobe ? (src_addr == src_len) : (src_addr != src_len);
  assign dst_term = dst_strobe ? (dst_addr == dst_len) : (dst_addr != dst_len);
  // address steps on every read, the terminating one too
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n || rewind) begin
      src_addr <= 4'h0;
      dst_addr <= 4'h0;
      n_rd     <= 8'h00;
    end else begin
      if (src_strobe) begin
        src_addr <= src_addr + 4'h1;
        n_rd     <= n_rd + 8'h01;
      end
      if (dst_strobe && dst_addr != dst_len) begin
        dst_mem[dst_addr] <= dst_data;
        dst_addr          <= dst_addr + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/test_unwrapped_memory_block_mover.sv
// self-checking bench for the unwrapped memory block mover
`timescale 1ns/1ps
`default_nettype none
module test_unwrapped_memory_block_mover;
  // ******************************************************
  // signals
  // ******************************************************
  logic       core_clk, rst_n, dev_selected, opt_space_fill, opt_cmd80, rewind;
  logic       stop_clear_command, move_parameter_command, move_command, status_read_command;
  logic [7:0] cmd_data, status_byte, fill_byte, src_data, dst_data;
  logic       src_strobe, src_term, dst_strobe, dst_term, irq;
  logic [3:0] src_len, dst_len;
  int         n_mismatch, compares;
  localparam int STOP = 0, PARM = 1, MOVE = 2, STAT = 3;
  typedef struct packed {logic opt; logic [7:0] fill;} umbm_row_t;
  umbm_row_t rows [3] = '{'{1'b0, 8'h00}, '{1'b1, 8'h20}, '{1'b0, 8'h00}};
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  umbm_mover i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .dev_selected(dev_selected),
    .stop_clear_command(stop_clear_command), .move_parameter_command(move_parameter_command),
    .move_command(move_command), .status_read_command(status_read_command),
    .cmd_data(cmd_data), .status_byte(status_byte), .opt_space_fill(opt_space_fill),
    .opt_cmd80(opt_cmd80), .fill_byte(fill_byte), .src_strobe(src_strobe),
    .src_data(src_data), .src_term(src_term), .dst_strobe(dst_strobe),
    .dst_data(dst_data), .dst_term(dst_term), .irq(irq));
  umbm_mem_model i_mem (
    .core_clk(core_clk), .rst_n(rst_n), .rewind(rewind), .src_len(src_len),
    .dst_len(dst_len), .src_strobe(src_strobe), .src_data(src_data), .src_term(src_term),
    .dst_strobe(dst_strobe), .dst_data(dst_data), .dst_term(dst_term));
  // ******************************************************
  // tasks
  // ******************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one-cycle command pulse launched off the falling edge
  task automatic cmd(input int k, input logic [7:0] d);
    @(negedge core_clk);
    cmd_data = d;
    case (k)
      STOP: stop_clear_command = 1'b1;
      PARM: move_parameter_command = 1'b1;
      MOVE: move_command = 1'b1;
      default: status_read_command = 1'b1;
    endcase
    @(negedge core_clk);
    {stop_clear_command, move_parameter_command, move_command, status_read_command} = 4'h0;
  endtask
  task automatic stat(input logic [7:0] exp);
    cmd(STAT, 8'h00);
    chk("status_byte", exp, status_byte);
  endtask
  // reset the memory model's addresses and set where each side ends
  task automatic rew(input logic [3:0] s, input logic [3:0] d);
    @(negedge core_clk);
    {src_len, dst_len, rewind} = {s, d, 1'b1};
    @(negedge core_clk);
    rewind = 1'b0;
  endtask
  // bounded: eleven accesses fit well inside the limit
  task automatic wait_idle;
    for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(negedge core_clk);
    if (irq !== 1'b1) begin
      n_mismatch++;
      $display("unexpected irq: expected 1, seen %b", irq);
    end
  endtask
  task automatic conclude;
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog: the tests need about 40000 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    $display("unexpected watchdog: run did not finish");
    conclude();
  end
  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    {dev_selected, opt_space_fill, opt_cmd80, rewind, rst_n} = 5'h10;
    {stop_clear_command, move_parameter_command, move_command, status_read_command} = 4'h0;
    {cmd_data, src_len, dst_len} = {8'h00, 4'h5, 4'hf};
    repeat (5) @(negedge core_clk);
    chk("irq", 8'h01, {7'h00, irq});
    chk("status_byte", 8'h00, status_byte);
    rst_n = 1'b1;
    // option rows: fill byte follows option one
    for (int i = 0; i < 3; i++) begin
      opt_space_fill = rows[i].opt;
      repeat (2) @(negedge core_clk);
      chk("fill_byte", rows[i].fill, fill_byte);
    end
    $display("reset and option rows done");
    stat(8'h80);
    cmd(PARM, 8'h00);
    cmd(MOVE, 8'h00);
    chk("irq", 8'h01, {7'h00, irq});
    cmd(PARM, 8'h80);
    dev_selected = 1'b0;
    cmd(MOVE, 8'h00);
    chk("irq", 8'h01, {7'h00, irq});
    dev_selected = 1'b1;
    $display("refused moves done");
    // plain unwrapped move of five bytes, null and space among them
    cmd(STOP, 8'h00);
    rew(4'h5, 4'hf);
    cmd(MOVE, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    wait_idle;
    chk("stored", 8'h05, {4'h0, i_mem.dst_addr});
    for (int k = 0; k < 5; k++) chk("dst byte", {k[3:0], 4'h0}, i_mem.dst_mem[k]);
    chk("reads", 8'h06, i_mem.n_rd);
    stat(8'ha0);
    $display("unwrapped move done");
    // option two, destination ends after one byte, then resume
    cmd(STOP, 8'h00);
    cmd(PARM, 8'h00);
    opt_cmd80 = 1'b1;
    cmd(MOVE, 8'h7f);
    chk("irq", 8'h01, {7'h00, irq});
    rew(4'h3, 4'h1);
    cmd(MOVE, 8'h80);
    wait_idle;
    stat(8'h90);
    chk("stored", 8'h01, {4'h0, i_mem.dst_addr});
    dst_len = 4'hf;
    cmd(MOVE, 8'h80);
    wait_idle;
    chk("stored", 8'h03, {4'h0, i_mem.dst_addr});
    for (int k = 0; k < 3; k++) chk("dst byte", {k[3:0], 4'h0}, i_mem.dst_mem[k]);
    chk("reads", 8'h04, i_mem.n_rd);
    cmd(STAT, 8'h00);
    chk("flags", 8'ha0, status_byte & 8'ha0);
    $display("halt and resume done");
    // stop in mid-move must drop the byte already buffered
    cmd(STOP, 8'h00);
    rew(4'h9, 4'hf);
    cmd(MOVE, 8'h80);
    repeat (1600) @(negedge core_clk);
    cmd(STOP, 8'h00);
    chk("irq", 8'h01, {7'h00, irq});
    stat(8'h80);
    rew(4'h2, 4'hf);
    cmd(MOVE, 8'h80);
    wait_idle;
    chk("stored", 8'h02, {4'h0, i_mem.dst_addr});
    $display("stop and clear done");
    conclude();
  end
endmodule
`default_nettype wire
